/* File: controller_model.sv */
/*
  Controller model for the wake pin and direct inputs.
  Assumes bench requests; pins change just after the clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module controller_model (
  // Clock
  input wire logic sys_clk,
  // Bench requests
  input wire logic sleep_req,
  input wire logic [1:0] din_req,
  // Pins
  output logic wake_reset_n,
  output logic [1:0] direct_inputs
);
  // ==========================================
  // Pin drive
  initial wake_reset_n = 1'b1;
  initial direct_inputs = 2'h0;
  always @(posedge sys_clk)
  begin
    wake_reset_n <= !sleep_req;
    direct_inputs <= din_req;
  end
endmodule
`default_nettype wire

/* File: retry_sequencer.sv */
/*
  Auto-retry sequencer and 4-bit retry counter for one channel.
  Assumes a one-cycle tick of one microsecond from the main block.
*/
`timescale 1ns/10ps
`default_nettype none
module retry_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  // Configuration
  input wire logic enable,
  input wire logic unlimited,
  input wire logic [1:0] period_sel,
  // Fault view
  input wire logic fault_event,
  input wire logic cause_present,
  input wire logic retry_condition,
  input wire logic clear_count,
  // Results
  output logic hold_off,
  output logic retry_start,
  output logic latch_now,
  output logic [3:0] count,
  output logic full
);
  supply_fault_pkg::retry_state_type state_reg, state_next;
  logic [11:0] timer_reg, timer_next;
  logic [3:0] count_reg, count_next;
  logic last_used_reg, last_used_next;

  // ============================================================
  // Sequence
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    count_next = count_reg;
    last_used_next = last_used_reg;
    retry_start = 1'b0;
    latch_now = 1'b0;
    case (state_reg)
      supply_fault_pkg::RETRY_IDLE:
        if (fault_event)
        begin
          // Disabled, or the last allowed retry already spent
          if (!enable || (!unlimited && last_used_reg))
            latch_now = 1'b1;
          else
          begin
            state_next = supply_fault_pkg::RETRY_WAIT_CAUSE;
            if (!unlimited && count_reg == supply_fault_pkg::RETRY_MAX)
              last_used_next = 1'b1;
          end
        end
      supply_fault_pkg::RETRY_WAIT_CAUSE:
        if (!enable)
        begin
          state_next = supply_fault_pkg::RETRY_IDLE;
          latch_now = 1'b1;
        end
        else if (!retry_condition)
          state_next = supply_fault_pkg::RETRY_IDLE;
        else if (!cause_present)
        begin
          state_next = supply_fault_pkg::RETRY_WAIT_PERIOD;
          timer_next = supply_fault_pkg::retry_period_ticks(period_sel);
        end
      supply_fault_pkg::RETRY_WAIT_PERIOD:
        if (!enable)
        begin
          state_next = supply_fault_pkg::RETRY_IDLE;
          latch_now = 1'b1;
        end
        else if (tick)
        begin
          if (timer_reg == 12'h000)
          begin
            state_next = supply_fault_pkg::RETRY_IDLE;
            retry_start = 1'b1;
            if (!unlimited && count_reg != supply_fault_pkg::RETRY_MAX)
              count_next = count_reg + 4'h1;
          end
          else
            timer_next = timer_reg - 12'h001;
        end
      default:
        state_next = supply_fault_pkg::RETRY_IDLE;
    endcase
    if (clear_count)
    begin
      count_next = 4'h0;
      last_used_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= supply_fault_pkg::RETRY_IDLE;
      timer_reg <= 12'h000;
      count_reg <= 4'h0;
      last_used_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      count_reg <= count_next;
      last_used_reg <= last_used_next;
    end
  end

  assign hold_off = (state_reg != supply_fault_pkg::RETRY_IDLE);
  assign count = count_reg;
  assign full = (count_reg == supply_fault_pkg::RETRY_MAX);
endmodule
`default_nettype wire

/* File: supply_fault_latch_retry.sv */
/*
  Supply fault handling for a dual high-side switch: under-voltage
  latching and warning, fault flags, fail-safe entry, power-on flag
  and auto-retry. Assumes supply monitors and detectors arrive as
  asynchronous levels and software uses the plain register port.
*/
// Function
// - Under-voltage: channels off, fault low, flag set
// - UV ends, request off: warning until turn-on
// - UV ends, request on, retry off: off until delatch
// - Latched UV flag cleared by read or flag reset, not by turn-on
// - UV retry starts when condition disappears
// - Extended range keeps settings and flags
// - Low supply defers over-temperature flag report
// - Flags reset on supply loss or read; power-on flag on read only
// - Faults switch off at fast rate
// - Logic supply loss enters fail-safe, direct control
// - Fail-safe still reports faults on pin
// - Without enable, stay under register control
// - First supply rising above POR sets power-on flag
// - Wake-up also sets power-on flag
// - Only latchable faults trigger retry
// - Retry condition ORs channel flags with UV
// - Retry follows config bits, count reads back
// - Retry disabled latches faults at once
// - Limited retry counts to fifteen
// - Counter cleared on listed events
`timescale 1ns/10ps
`default_nettype none
module supply_fault_latch_retry #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [supply_fault_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [supply_fault_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [supply_fault_pkg::DATA_W-1:0] reg_rd_data,
  // Supply monitors
  input wire logic supply_undervoltage,
  input wire logic supply_below_lowest,
  input wire logic supply_overvoltage,
  input wire logic logic_supply_fail,
  input wire logic supply_below_por,
  input wire logic logic_below_por,
  // Wake and direct control
  input wire logic wake_reset_n,
  input wire logic [1:0] direct_inputs,
  input wire logic [1:0] load_type_select,
  // Channel detectors
  input wire logic [1:0] overcurrent_detect,
  input wire logic [1:0] short_circuit_detect,
  input wire logic [1:0] overtemp_detect,
  // Outputs
  output logic [1:0] channel_enable,
  output logic [1:0] fast_turn_off,
  output logic fault_status_n,
  output logic failsafe_active
);
  localparam int SYNC_W = 17;

  logic [SYNC_W-1:0] sync_q;
  logic uv, low, ov, vdd_fail, pwr_por, vdd_por, wake_s;
  logic [1:0] dir_s, load_type_select_s, oc_s, sc_s, ot_s;
  logic awake, both_below, por_event, fs_entry, reg_reset, flag_reset;
  logic wr_ok, rd_ok, stat_rd, fault_rd, delatch, uv_fall, uv_rise, any_req;
  logic any_on_rise, any_latched, any_cause;

  logic [supply_fault_pkg::TICK_CNT_W-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [4:0] gc_reg, gc_next;
  logic [7:0] rc_reg, rc_next;
  logic uv_flag_reg, uv_flag_next, uv_latch_reg, uv_latch_next;
  logic ov_flag_reg, ov_flag_next, por_flag_reg, por_flag_next;
  logic failsafe_reg, failsafe_next, uv_d_reg, awake_d_reg, pwr_por_d_reg, vdd_por_d_reg;
  logic [supply_fault_pkg::DATA_W-1:0] rd_data_next;
  logic fsn_next;

  logic [1:0] req, latched_v, cause_v, on_next_v, fast_v, full_v;
  logic [1:0] oc_f, sc_f, ot_f;
  logic [3:0] cnt_v [0:1];

  // ============================================================
  // Input synchronisers
  sync_2ff #(.WIDTH(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({supply_undervoltage, supply_below_lowest, supply_overvoltage,
               logic_supply_fail, supply_below_por, logic_below_por, wake_reset_n,
               direct_inputs, load_type_select, overcurrent_detect,
               short_circuit_detect, overtemp_detect}),
    .sync_out(sync_q)
  );
  assign {uv, low, ov, vdd_fail, pwr_por, vdd_por, wake_s, dir_s, load_type_select_s, oc_s, sc_s, ot_s}
    = sync_q;

  // ============================================================
  // Supply events
  assign awake = wake_s | (|dir_s);
  assign both_below = pwr_por & vdd_por;
  assign por_event = (pwr_por_d_reg & ~pwr_por & vdd_por)
                   | (vdd_por_d_reg & ~vdd_por & pwr_por)
                   | (awake & ~awake_d_reg & (~pwr_por | ~vdd_por));
  assign fs_entry = vdd_fail & gc_reg[supply_fault_pkg::GC_FAIL_EN_BIT] & ~failsafe_reg;
  assign reg_reset = fs_entry | failsafe_reg | por_event;
  assign flag_reset = (vdd_fail & ~uv & ~low) | both_below | por_event;
  assign uv_fall = uv_d_reg & ~uv;
  assign uv_rise = uv & ~uv_d_reg;
  assign wr_ok = reg_wr & ~failsafe_reg;
  assign rd_ok = reg_rd & ~vdd_fail;
  assign stat_rd = rd_ok & (reg_addr == supply_fault_pkg::STATUS_ADDR);
  assign fault_rd = rd_ok & (reg_addr == supply_fault_pkg::FAULT_ADDR);
  assign delatch = wr_ok & (reg_addr == supply_fault_pkg::GENERAL_CONFIG_ADDR)
                 & reg_wr_data[supply_fault_pkg::GC_DELATCH_BIT];
  assign any_req = |req;
  assign any_on_rise = |(on_next_v & ~channel_enable);
  assign any_latched = |latched_v;
  assign any_cause = |cause_v;

  // ============================================================
  // Per-channel fault, latch and retry
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : g_ch
      logic oc_reg, oc_next, sc_reg, sc_next, ot_reg, ot_next, ot_pend_reg, ot_pend_next;
      logic latched_reg, latched_next, cause_d_reg, en_d_reg, unl_d_reg;
      logic retry_en, unl, cause, chan_cause, ev, cond, clr_cnt, hold, start, latch_now;
      logic [3:0] cfg;

      assign cfg = rc_reg[g*supply_fault_pkg::RC_W +: supply_fault_pkg::RC_W];
      assign retry_en = ~(cfg[supply_fault_pkg::RC_EN_BIT] ^ load_type_select_s[g]);
      assign unl = cfg[supply_fault_pkg::RC_UNL_BIT];
      assign chan_cause = oc_s[g] | sc_s[g] | ot_s[g];
      assign cause = chan_cause | uv;
      // Latchable faults only; UV retried only when enabled
      assign ev = (chan_cause & ~cause_d_reg) | (uv_rise & retry_en);
      // Channel flags with shared UV flag
      assign cond = oc_reg | sc_reg | ot_reg | uv_flag_reg;
      assign clr_cnt = fs_entry | (awake & ~awake_d_reg) | por_event
                     | (unl & ~unl_d_reg) | (en_d_reg & ~retry_en);
      assign req[g] = failsafe_reg ? dir_s[g] : gc_reg[supply_fault_pkg::GC_REQ_LO_BIT + g];

      retry_sequencer u_retry (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick_reg),
        .enable(retry_en),
        .unlimited(unl),
        .period_sel(cfg[supply_fault_pkg::RC_PER_LO_BIT +: 2]),
        .fault_event(ev),
        .cause_present(cause),
        .retry_condition(cond),
        .clear_count(clr_cnt),
        .hold_off(hold),
        .retry_start(start),
        .latch_now(latch_now),
        .count(cnt_v[g]),
        .full(full_v[g])
      );

      always_comb
      begin
        ot_pend_next = (ot_pend_reg | (ot_s[g] & low)) & ~flag_reset;
        if (ot_pend_reg & ~uv)
          ot_pend_next = 1'b0;
        oc_next = oc_reg;
        sc_next = sc_reg;
        ot_next = ot_reg;
        // Read clears once cause gone and delatched
        if ((fault_rd & ~latched_reg) | flag_reset)
        begin
          oc_next = oc_next & oc_s[g];
          sc_next = sc_next & sc_s[g];
          ot_next = ot_next & ot_s[g];
          if (flag_reset)
          begin
            oc_next = 1'b0;
            sc_next = 1'b0;
            ot_next = 1'b0;
          end
        end
        // Set wins over any clear
        oc_next = oc_next | oc_s[g];
        sc_next = sc_next | sc_s[g];
        ot_next = ot_next | (ot_s[g] & ~low) | (ot_pend_reg & ~uv);
        latched_next = latched_reg;
        if (delatch | por_event)
          latched_next = 1'b0;
        // UV end with request on stays off
        if (latch_now | (uv_fall & req[g] & ~retry_en))
          latched_next = 1'b1;
        // Faults and UV force the channel off
        on_next_v[g] = req[g] & ~latched_reg & ~hold & ~cause & ~uv_fall
                     & ~(ov & ~gc_reg[supply_fault_pkg::GC_OVERVOLTAGE_DISABLE_BIT]);
        fast_v[g] = req[g] & cause;
      end

      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          oc_reg <= 1'b0;
          sc_reg <= 1'b0;
          ot_reg <= 1'b0;
          ot_pend_reg <= 1'b0;
          latched_reg <= 1'b0;
          cause_d_reg <= 1'b0;
          en_d_reg <= 1'b0;
          unl_d_reg <= 1'b0;
        end
        else
        begin
          oc_reg <= oc_next;
          sc_reg <= sc_next;
          ot_reg <= ot_next;
          ot_pend_reg <= ot_pend_next;
          latched_reg <= latched_next;
          cause_d_reg <= chan_cause;
          en_d_reg <= retry_en;
          unl_d_reg <= unl;
        end
      end

      assign latched_v[g] = latched_reg;
      assign cause_v[g] = chan_cause;
      assign oc_f[g] = oc_reg;
      assign sc_f[g] = sc_reg;
      assign ot_f[g] = ot_reg;
    end
  endgenerate

  // ============================================================
  // Shared state and register file
  always_comb
  begin
    div_next = div_reg + {{(supply_fault_pkg::TICK_CNT_W-1){1'b0}}, 1'b1};
    tick_next = 1'b0;
    if (div_reg == supply_fault_pkg::TICK_CNT_W'(supply_fault_pkg::TICK_CYCLES - 1))
    begin
      div_next = '0;
      tick_next = 1'b1;
    end
    // Settings change only by write or reset events
    gc_next = gc_reg;
    rc_next = rc_reg;
    if (wr_ok && reg_addr == supply_fault_pkg::GENERAL_CONFIG_ADDR)
      gc_next = {1'b0, reg_wr_data[3:0]};
    if (wr_ok && reg_addr == supply_fault_pkg::RETRY_CONFIG_ADDR)
      rc_next = reg_wr_data[7:0];
    if (reg_reset)
    begin
      gc_next = supply_fault_pkg::GC_RESET;
      rc_next = supply_fault_pkg::RC_RESET;
    end
    failsafe_next = (failsafe_reg | fs_entry) & vdd_fail;
    uv_latch_next = uv_latch_reg;
    if ((stat_rd & ~uv) | flag_reset)
      uv_latch_next = 1'b0;
    if (uv_fall & any_req)
      uv_latch_next = 1'b1;
    uv_flag_next = uv_flag_reg;
    // Latched case cleared by status read or flag reset, not by turn-on
    if (stat_rd & uv_latch_reg)
      uv_flag_next = 1'b0;
    // Warning cleared by an output turning on
    if (~uv_latch_reg & ~(uv_fall & any_req) & any_on_rise)
      uv_flag_next = 1'b0;
    if (flag_reset)
      uv_flag_next = 1'b0;
    uv_flag_next = uv_flag_next | uv;
    ov_flag_next = (ov_flag_reg & ~((stat_rd & ~ov) | flag_reset)) | ov;
    por_flag_next = (por_flag_reg & ~stat_rd) | por_event;
    // Fault pin from latched or active faults
    fsn_next = ~(uv | any_latched | any_cause
             | (ov & ~gc_reg[supply_fault_pkg::GC_OVERVOLTAGE_DISABLE_BIT]));
    rd_data_next = '0;
    if (rd_ok)
      case (reg_addr)
        supply_fault_pkg::GENERAL_CONFIG_ADDR: rd_data_next[4:0] = gc_reg;
        supply_fault_pkg::RETRY_CONFIG_ADDR: rd_data_next[7:0] = rc_reg;
        supply_fault_pkg::STATUS_ADDR:
        begin
          rd_data_next[supply_fault_pkg::ST_UV_BIT] = uv_flag_reg;
          rd_data_next[supply_fault_pkg::ST_OV_BIT] = ov_flag_reg;
          rd_data_next[supply_fault_pkg::ST_FAILSAFE_BIT] = failsafe_reg;
          rd_data_next[supply_fault_pkg::ST_RFULL_LO_BIT +: 2] = full_v;
          rd_data_next[supply_fault_pkg::ST_POR_BIT] = por_flag_reg;
        end
        supply_fault_pkg::FAULT_ADDR:
        begin
          rd_data_next[supply_fault_pkg::FT_OC_BIT] = oc_f[0];
          rd_data_next[supply_fault_pkg::FT_SC_BIT] = sc_f[0];
          rd_data_next[supply_fault_pkg::FT_OT_BIT] = ot_f[0];
          rd_data_next[supply_fault_pkg::FT_STRIDE + supply_fault_pkg::FT_OC_BIT] = oc_f[1];
          rd_data_next[supply_fault_pkg::FT_STRIDE + supply_fault_pkg::FT_SC_BIT] = sc_f[1];
          rd_data_next[supply_fault_pkg::FT_STRIDE + supply_fault_pkg::FT_OT_BIT] = ot_f[1];
        end
        supply_fault_pkg::RETRY_COUNT0_ADDR: rd_data_next[supply_fault_pkg::RCNT_LO_BIT +: 4] = cnt_v[0];
        supply_fault_pkg::RETRY_COUNT1_ADDR: rd_data_next[supply_fault_pkg::RCNT_LO_BIT +: 4] = cnt_v[1];
        default: rd_data_next = '0;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      gc_reg <= supply_fault_pkg::GC_RESET;
      rc_reg <= supply_fault_pkg::RC_RESET;
      failsafe_reg <= 1'b0;
      uv_latch_reg <= 1'b0;
      uv_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
      por_flag_reg <= 1'b0;
      uv_d_reg <= 1'b0;
      awake_d_reg <= 1'b0;
      pwr_por_d_reg <= 1'b0;
      vdd_por_d_reg <= 1'b0;
      reg_rd_data <= '0;
      channel_enable <= 2'h0;
      fast_turn_off <= 2'h0;
      fault_status_n <= 1'b1;
      failsafe_active <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      gc_reg <= gc_next;
      rc_reg <= rc_next;
      failsafe_reg <= failsafe_next;
      uv_latch_reg <= uv_latch_next;
      uv_flag_reg <= uv_flag_next;
      ov_flag_reg <= ov_flag_next;
      por_flag_reg <= por_flag_next;
      uv_d_reg <= uv;
      awake_d_reg <= awake;
      pwr_por_d_reg <= pwr_por;
      vdd_por_d_reg <= vdd_por;
      reg_rd_data <= rd_data_next;
      channel_enable <= on_next_v;
      fast_turn_off <= fast_v;
      fault_status_n <= fsn_next;
      failsafe_active <= failsafe_next;
    end
  end
endmodule
`default_nettype wire

/* File: supply_fault_latch_retry_tb_top.sv */
/*
  Bench for the supply fault block: register port and supply events.
  Assumes the controller model drives the wake and direct pins.
*/
`timescale 1ns/10ps
`default_nettype none
module supply_fault_latch_retry_tb_top;
  // ==========================================
  // Signals and instances
  logic sys_clk, rst_n, reg_wr, reg_rd, fault_status_n, failsafe_active, wake_reset_n;
  logic supply_undervoltage, supply_below_lowest, supply_overvoltage, logic_supply_fail;
  logic supply_below_por, logic_below_por, sleep_req;
  logic [7:0] reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data, rdv;
  logic [1:0] direct_inputs, load_type_select, overcurrent_detect, short_circuit_detect;
  logic [1:0] overtemp_detect, channel_enable, fast_turn_off, din_req;
  int num_errors, n_compared;
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  controller_model controller_model_inst (.*);
  supply_fault_latch_retry supply_fault_latch_retry_inst (.*);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rd_data;
  endtask
  task automatic wt;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_uv_warn;
    @(posedge sys_clk) supply_undervoltage <= 1'b1;
    wt();
    cmp({15'h0, fault_status_n}, 16'h0000);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv & 16'h0001, 16'h0001);
    @(posedge sys_clk) supply_undervoltage <= 1'b0;
    wt();
    cmp({15'h0, fault_status_n}, 16'h0001);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv & 16'h0001, 16'h0001);
    wr(8'h00, 16'h0004);
    wt();
    cmp({14'h0, channel_enable}, 16'h0001);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv & 16'h0001, 16'h0000);
  endtask
  task automatic t_uv_latch;
    @(posedge sys_clk) supply_undervoltage <= 1'b1;
    wt();
    @(posedge sys_clk) supply_undervoltage <= 1'b0;
    wt();
    cmp({14'h0, channel_enable}, 16'h0000);
    cmp({15'h0, fault_status_n}, 16'h0000);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv & 16'h0001, 16'h0001);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv & 16'h0001, 16'h0000);
    wr(8'h00, 16'h0014);
    wt();
    cmp({14'h0, channel_enable}, 16'h0001);
  endtask
  task automatic t_fail;
    wr(8'h00, 16'h0000);
    @(posedge sys_clk) logic_supply_fail <= 1'b1;
    wt();
    wr(8'h00, 16'h0008);
    wt();
    cmp({15'h0, failsafe_active}, 16'h0000);
    cmp({14'h0, channel_enable}, 16'h0002);
    @(posedge sys_clk) logic_supply_fail <= 1'b0;
    wt();
    wr(8'h00, 16'h0001);
    @(posedge sys_clk) logic_supply_fail <= 1'b1;
    din_req <= 2'h1;
    wt();
    cmp({15'h0, failsafe_active}, 16'h0001);
    cmp({14'h0, channel_enable}, 16'h0001);
    @(posedge sys_clk) overcurrent_detect <= 2'h1;
    wt();
    cmp({15'h0, fault_status_n}, 16'h0000);
    cmp({14'h0, fast_turn_off}, 16'h0001);
    cmp({14'h0, channel_enable}, 16'h0000);
    rd(supply_fault_pkg::STATUS_ADDR);
    cmp(rdv, 16'h0000);
  endtask
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Sequence and watchdog
  initial
  begin
    {rst_n, reg_wr, reg_rd, sleep_req, reg_addr, reg_wr_data, din_req} = '0;
    {supply_undervoltage, supply_below_lowest, supply_overvoltage, logic_supply_fail} = '0;
    {supply_below_por, logic_below_por, load_type_select, overcurrent_detect} = '0;
    {short_circuit_detect, overtemp_detect} = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Wake-up after reset resets config; write only once it has passed
    wt();
    // Retry off on both lighting channels
    wr(supply_fault_pkg::RETRY_CONFIG_ADDR, 16'h0011);
    rd(8'hFC);
    cmp(rdv, 16'h0000);
    t_uv_warn();
    t_uv_latch();
    t_fail();
    complete_run();
  end
  initial
  begin
    #20000;
    num_errors++;
    $display("BAD %0t timeout", $time);
    complete_run();
  end
endmodule
`default_nettype wire

/* File: supply_fault_pkg.sv */
/*
  Constants, register map and state type for the supply fault,
  latch and auto-retry logic of a dual high-side switch.
  Assumes a 250 MHz system clock and a plain register port.
*/
`default_nettype none
package supply_fault_pkg;
  // ============================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 8;
  // Retry periods, in microseconds, one per period select code
  localparam logic [11:0] RETRY_PERIOD_US_0 = 12'h096;
  localparam logic [11:0] RETRY_PERIOD_US_1 = 12'h12C;
  localparam logic [11:0] RETRY_PERIOD_US_2 = 12'h258;
  localparam logic [11:0] RETRY_PERIOD_US_3 = 12'h4B0;
  localparam logic [3:0] RETRY_MAX = 4'hF;
  // ============================================================
  // Register port and map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] GENERAL_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] RETRY_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] FAULT_ADDR = 8'h0C;
  localparam logic [7:0] RETRY_COUNT0_ADDR = 8'h10;
  localparam logic [7:0] RETRY_COUNT1_ADDR = 8'h14;
  // General config fields
  localparam int GC_FAIL_EN_BIT = 0;
  localparam int GC_OVERVOLTAGE_DISABLE_BIT = 1;
  localparam int GC_REQ_LO_BIT = 2;
  localparam int GC_DELATCH_BIT = 4;
  localparam logic [4:0] GC_RESET = 5'h00;
  // Retry config: four bits a channel
  localparam int RC_EN_BIT = 0;
  localparam int RC_UNL_BIT = 1;
  localparam int RC_PER_LO_BIT = 2;
  localparam int RC_W = 4;
  localparam logic [7:0] RC_RESET = 8'h00;
  // Status fields
  localparam int ST_UV_BIT = 0;
  localparam int ST_OV_BIT = 1;
  localparam int ST_FAILSAFE_BIT = 2;
  localparam int ST_RFULL_LO_BIT = 4;
  localparam int ST_POR_BIT = 6;
  // Fault fields, four bits a channel
  localparam int FT_OC_BIT = 0;
  localparam int FT_SC_BIT = 1;
  localparam int FT_OT_BIT = 2;
  localparam int FT_STRIDE = 4;
  localparam int RCNT_LO_BIT = 4;

  typedef enum logic [1:0] {RETRY_IDLE, RETRY_WAIT_CAUSE, RETRY_WAIT_PERIOD} retry_state_type;

  function automatic logic [11:0] retry_period_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: retry_period_ticks = RETRY_PERIOD_US_0;
      2'h1: retry_period_ticks = RETRY_PERIOD_US_1;
      2'h2: retry_period_ticks = RETRY_PERIOD_US_2;
      default: retry_period_ticks = RETRY_PERIOD_US_3;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: supply_fault_sva.sv */
/*
  Port checker for the supply fault block.
  Bound to the top module; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module supply_fault_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [supply_fault_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [supply_fault_pkg::DATA_W-1:0] reg_rd_data,
  // Monitors
  input wire logic supply_undervoltage,
  input wire logic logic_supply_fail,
  // Outputs
  input wire logic [1:0] channel_enable,
  input wire logic [1:0] fast_turn_off,
  input wire logic fault_status_n,
  input wire logic failsafe_active
);
  // ==========================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_uv_all_off: assert property (supply_undervoltage [*4] |-> channel_enable == 2'h0)
    else $error("channel on during undervoltage");
  chk_uv_pin_low: assert property (supply_undervoltage [*4] |-> !fault_status_n)
    else $error("fault pin high during undervoltage");
  chk_fast_excl: assert property ((fast_turn_off & channel_enable) == 2'h0)
    else $error("channel on while forced off");
  chk_fs_cause: assert property ($rose(failsafe_active) |->
    $past(logic_supply_fail, 2) || $past(logic_supply_fail, 3))
    else $error("failsafe without supply loss");
  chk_fail_read: assert property (logic_supply_fail [*5] ##0 $past(reg_rd) |->
    reg_rd_data == 16'h0000)
    else $error("readback during supply loss");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rd_data == 16'h0000)
    else $error("read data outside its cycle");
  chk_reset_quiet: assert property ($rose(rst_n) |->
    fault_status_n && !failsafe_active && channel_enable == 2'h0)
    else $error("outputs not quiet after reset");
  chk_uv_flag_rd: assert property ((supply_undervoltage && !logic_supply_fail) [*6] ##0
    ($past(reg_rd) && $past(reg_addr) == supply_fault_pkg::STATUS_ADDR) |->
    reg_rd_data[0])
    else $error("flag clear during undervoltage");
  cover property ($rose(failsafe_active));
  cover property (supply_undervoltage [*4]);
  cover property ($past(reg_rd) && reg_rd_data != 16'h0000);
endmodule
bind supply_fault_latch_retry supply_fault_sva supply_fault_sva_inst (.*);
`default_nettype wire

/* File: sync_2ff.sv */
/*
  Two-flip-flop synchroniser for a bus of independent levels.
  Assumes each bit is a level that changes slowly against sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  // ============================================================
  // First stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stage_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule
`default_nettype wire
